// ---- hw/delayed_oneshot_continuous_timer.sv ----
// One channel of a 16-bit down-counting output timer: delayed single-shot
// with correction, and continuous output.
// Assumes the software side drives sw_i on core_clk_i and that ext_enable_i
// is an asynchronous pin.
//
// Operation
// - start by software enable or external input.
// - delayed: preset, reload at first, stop at second.
// - delayed: output toggles at both underflows only.
// - delayed: interrupt at first and second underflow.
// - each phase lasts loaded value plus one.
// - correction added next tick, decrement cancelled.
// - correction overflow raises no interrupt.
// - underflow stop beats external enable.
// - software enable write beats underflow stop.
// - software disable beats external enable.
// - counter reads all ones after underflow reload.
// - continuous: reload and restart on every underflow.
// - continuous: toggle at start and each underflow.
// - continuous: interrupt at every underflow.
// - start latency follows the count clock.
// - stop on underflow clears the enable bit.
`timescale 1ns/10ps
`default_nettype none
`include "oneshot_timer_map.svh"

module delayed_oneshot_continuous_timer #(
  parameter int CLK_DIV = `TMR_CLK_DIV_DEF
) (
  input wire logic core_clk_i,
  input wire logic nrst_i,
  input wire oneshot_timer_pkg::mode_e mode_i,
  input wire oneshot_timer_pkg::sw_req_s sw_i,
  input wire logic ext_enable_i,
  output logic channel_count_enable_bit_o,
  output oneshot_timer_pkg::count_t count_o,
  output logic ff_o,
  output logic irq_o
);
  import oneshot_timer_pkg::*;

  // Elaboration stops on a divide ratio outside 1..255.
  if (CLK_DIV < 1 || CLK_DIV > 255)
  begin : g_bad_clk_div
    $error("CLK_DIV must lie in 1..255");
  end

  //////////////////////////////////////////////////////////////////////////
  // Reset release and pin synchroniser.

  logic rst_meta_reg;
  logic rst_n;
  logic ext_meta_reg;
  logic ext_sync_reg;
  logic ext_prev_reg;
  logic ext_rise;

  always_ff @(posedge core_clk_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      rst_meta_reg <= 1'b0;
      rst_n <= 1'b0;
    end
    else
    begin
      rst_meta_reg <= 1'b1;
      rst_n <= rst_meta_reg;
    end
  end

  always_ff @(posedge core_clk_i or negedge rst_n)
  begin
    if (!rst_n)
    begin
      ext_meta_reg <= 1'b0;
      ext_sync_reg <= 1'b0;
      ext_prev_reg <= 1'b0;
    end
    else
    begin
      ext_meta_reg <= ext_enable_i;
      ext_sync_reg <= ext_meta_reg;
      ext_prev_reg <= ext_sync_reg;
    end
  end

  assign ext_rise = ext_sync_reg && !ext_prev_reg;

  //////////////////////////////////////////////////////////////////////////
  // Count clock divider: counting, start and underflow advance only on tick.

  logic [`TMR_DIV_W-1:0] div_reg;
  logic [`TMR_DIV_W-1:0] div_next;
  logic tick;

  assign tick = (div_reg == '0);

  always_comb
  begin
    if (tick)
    begin
      div_next = `TMR_DIV_W'(CLK_DIV - 1);
    end
    else
    begin
      div_next = div_reg - `TMR_DIV_W'(1);
    end
  end

  always_ff @(posedge core_clk_i or negedge rst_n)
  begin
    if (!rst_n)
    begin
      div_reg <= '0;
    end
    else
    begin
      div_reg <= div_next;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Timer state.

  count_t cnt_reg, cnt_next;
  count_t rld_reg, rld_next;
  count_t corr_reg, corr_next;
  logic corr_pend_reg, corr_pend_next;
  logic rld_pend_reg, rld_pend_next;
  logic cen_reg, cen_next;
  logic started_reg, started_next;
  logic ff_reg, ff_next;
  logic irq_reg, irq_next;
  phase_e phase_reg, phase_next;
  logic running;
  logic underflow;
  logic stop_uf;
  logic sw_cen;

  assign running = cen_reg && started_reg;
  assign underflow = tick && running && !rld_pend_reg && !corr_pend_reg
    && cnt_reg == `TMR_ZERO;
  assign stop_uf = underflow && mode_i == MODE_DELAYED && phase_reg == PH_PULSE;
  // software enable writes take effect only with the unlock
  assign sw_cen = sw_i.cen_wr && sw_i.cen_unlock;

  always_comb
  begin
    cnt_next = cnt_reg;
    rld_next = sw_i.rld_wr ? sw_i.rld_data : rld_reg;
    corr_next = corr_reg;
    corr_pend_next = corr_pend_reg;
    rld_pend_next = rld_pend_reg;
    cen_next = cen_reg;
    started_next = started_reg;
    ff_next = ff_reg;
    irq_next = 1'b0;
    phase_next = phase_reg;

    // start waits for the next count clock
    if (cen_reg && !started_reg && tick)
    begin
      started_next = 1'b1;
      phase_next = PH_DELAY;
      if (mode_i == MODE_CONTINUOUS)
      begin
        ff_next = !ff_reg;
      end
    end
    else if (running && tick)
    begin
      if (rld_pend_reg)
      begin
        // all ones gives way to reload minus one
        cnt_next = rld_reg - `TMR_ONE;
        rld_pend_next = 1'b0;
      end
      else if (corr_pend_reg)
      begin
        cnt_next = cnt_reg + corr_reg;
        corr_pend_next = 1'b0;
      end
      else
      begin
        // count down through zero into underflow
        cnt_next = cnt_reg - `TMR_ONE;
      end
      if (underflow)
      begin
        ff_next = !ff_reg;
        irq_next = 1'b1;
        if (stop_uf)
        begin
          started_next = 1'b0;
          phase_next = PH_IDLE;
        end
        else
        begin
          rld_pend_next = 1'b1;
          phase_next = PH_PULSE;
        end
      end
    end

    // software writes the correction amount as given
    if (sw_i.corr_wr && mode_i == MODE_DELAYED)
    begin
      corr_next = sw_i.corr_data;
      corr_pend_next = 1'b1;
    end
    if (sw_i.cnt_wr)
    begin
      cnt_next = sw_i.cnt_data;
    end

    if (ext_rise)
    begin
      cen_next = 1'b1;
    end
    if (stop_uf)
    begin
      cen_next = 1'b0;
    end
    if (sw_cen)
    begin
      cen_next = sw_i.cen_data;
    end
    if (!cen_next)
    begin
      started_next = 1'b0;
      phase_next = PH_IDLE;
      rld_pend_next = 1'b0;
    end
  end

  always_ff @(posedge core_clk_i or negedge rst_n)
  begin
    if (!rst_n)
    begin
      cnt_reg <= `TMR_CNT_RST;
      rld_reg <= `TMR_RLD_RST;
      corr_reg <= `TMR_CORR_RST;
      corr_pend_reg <= 1'b0;
      rld_pend_reg <= 1'b0;
      cen_reg <= 1'b0;
      started_reg <= 1'b0;
      ff_reg <= 1'b0;
      irq_reg <= 1'b0;
      phase_reg <= PH_IDLE;
    end
    else
    begin
      cnt_reg <= cnt_next;
      rld_reg <= rld_next;
      corr_reg <= corr_next;
      corr_pend_reg <= corr_pend_next;
      rld_pend_reg <= rld_pend_next;
      cen_reg <= cen_next;
      started_reg <= started_next;
      ff_reg <= ff_next;
      irq_reg <= irq_next;
      phase_reg <= phase_next;
    end
  end

  assign channel_count_enable_bit_o = cen_reg;
  assign count_o = cnt_reg;
  assign ff_o = ff_reg;
  assign irq_o = irq_reg;

  //////////////////////////////////////////////////////////////////////////
  // Checks beside the logic.

  default clocking cb @(posedge core_clk_i);
  endclocking
  default disable iff (!rst_n);

  sequence uf_s;
    underflow && !sw_i.cnt_wr;
  endsequence

  sequence all_ones_s;
    count_o == `TMR_ALL_ONES;
  endsequence

  reload_read_a: assert property (
    uf_s |=> all_ones_s)
    else $error("Counter not all ones after underflow.");
  reload_load_a: assert property (
    rld_pend_reg && running && tick && !sw_i.cnt_wr && cen_next
    |=> cnt_reg == $past(rld_reg) - `TMR_ONE)
    else $error("Reload did not load value minus one.");
  corr_add_a: assert property (
    running && tick && corr_pend_reg && !rld_pend_reg && !sw_i.cnt_wr
    |=> cnt_reg == $past(cnt_reg) + $past(corr_reg))
    else $error("Correction not added on the count clock.");
  corr_no_irq_a: assert property (
    running && tick && corr_pend_reg && !rld_pend_reg |=> !irq_o)
    else $error("Correction tick raised an interrupt.");
  uf_irq_ff_a: assert property (
    underflow |=> irq_o && ff_o != $past(ff_o))
    else $error("Underflow without toggle and interrupt.");
  irq_cause_a: assert property (
    irq_o |-> $past(underflow))
    else $error("Interrupt without an underflow.");
  stop_clear_a: assert property (
    stop_uf && !sw_cen |=> !channel_count_enable_bit_o)
    else $error("Stop did not clear the enable bit.");
  sw_enable_a: assert property (
    sw_cen && sw_i.cen_data |=> channel_count_enable_bit_o)
    else $error("Software enable lost.");
  sw_disable_a: assert property (
    sw_cen && !sw_i.cen_data |=> !channel_count_enable_bit_o)
    else $error("Software disable lost.");
  ext_start_a: assert property (
    ext_rise && !stop_uf && !sw_cen |=> channel_count_enable_bit_o)
    else $error("External enable did not start the timer.");
  cont_run_a: assert property (
    (underflow && mode_i == MODE_CONTINUOUS && !sw_cen) ##1 !sw_cen
    |-> channel_count_enable_bit_o ##1 channel_count_enable_bit_o)
    else $error("Continuous mode stopped by itself.");
  locked_a: assert property (
    sw_i.cen_wr && !sw_i.cen_unlock && !ext_rise && !stop_uf
    |=> channel_count_enable_bit_o == $past(channel_count_enable_bit_o))
    else $error("Locked enable bit changed.");

endmodule // delayed_oneshot_continuous_timer
`default_nettype wire

// ---- hw/oneshot_timer_map.svh ----
// Constants for the delayed single-shot / continuous timer channel.
// Assumes it is included by its bare name from the package and the design.
`ifndef ONESHOT_TIMER_MAP_SVH
`define ONESHOT_TIMER_MAP_SVH

`define TMR_WIDTH 16
`define TMR_CNT_RST 16'h0000
`define TMR_RLD_RST 16'h0000
`define TMR_CORR_RST 16'h0000
`define TMR_ALL_ONES 16'hffff
`define TMR_ONE 16'h0001
`define TMR_ZERO 16'h0000
`define TMR_CLK_DIV_DEF 4
`define TMR_DIV_W 8

`endif

// ---- hw/oneshot_timer_pkg.sv ----
// Types shared by the timer channel and whoever drives its software side.
// Assumes the constant header sits beside it.
`include "oneshot_timer_map.svh"

package oneshot_timer_pkg;

  typedef logic [`TMR_WIDTH-1:0] count_t;

  // One cycle strobes from the software side, each with its data.
  typedef struct packed
  {
    logic cnt_wr;
    count_t cnt_data;
    logic rld_wr;
    count_t rld_data;
    logic corr_wr;
    count_t corr_data;
    logic cen_wr;
    logic cen_data;
    logic cen_unlock;
  } sw_req_s;

  typedef enum logic [1:0]
  {
    MODE_DELAYED = 2'b00,
    MODE_CONTINUOUS = 2'b01
  } mode_e;

  typedef enum logic [1:0]
  {
    PH_IDLE = 2'b00,
    PH_DELAY = 2'b01,
    PH_PULSE = 2'b10
  } phase_e;

endpackage

// ---- tb/testbench.sv ----
// Self-checking bench for the delayed single-shot / continuous timer channel.
// Assumes the count clock divider is set to one, so a tick is one core cycle.
`timescale 1ns/10ps
`default_nettype none

module testbench;
  import oneshot_timer_pkg::*;

  typedef struct
  {
    int gap;
    logic ff;
    logic cen;
    logic has_nxt;
    count_t nxt;
  } note_s;

  logic core_clk_i = 1'b0;
  logic nrst_i = 1'b0;
  mode_e mode_i = MODE_DELAYED;
  sw_req_s sw_i = '0;
  logic ext_enable_i = 1'b0;
  logic cen_o;
  count_t count_o;
  logic ff_o;
  logic irq_o;
  note_s exp_q[$];
  note_s n;
  int num_errors = 0;
  int compares = 0;
  int cyc = 0;
  int ref_cyc = 0;
  int ticks = 0;
  int p;
  int r;
  int d;
  bit rst_done = 1'b0;
  bit chk_next = 1'b0;
  logic cen_prev = 1'b0;
  logic ffx = 1'b0;
  count_t nxt_val = '0;

  always #5 core_clk_i = ~core_clk_i;

  delayed_oneshot_continuous_timer #(.CLK_DIV(1)) u_delayed_oneshot_continuous_timer (
    .core_clk_i(core_clk_i),
    .nrst_i(nrst_i),
    .mode_i(mode_i),
    .sw_i(sw_i),
    .ext_enable_i(ext_enable_i),
    .channel_count_enable_bit_o(cen_o),
    .count_o(count_o),
    .ff_o(ff_o),
    .irq_o(irq_o)
  );

  //////////////////////////////////////////////////
  function automatic bit cnt(input bit bad);
    compares++;
    return bad;
  endfunction

  task automatic err(input string msg);
    num_errors++;
    $display("ERROR %0t: %s", $time, msg);
  endtask

  task automatic test_done;
    if (num_errors == 0 && compares > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask

  task automatic send(input sw_req_s q);
    @(negedge core_clk_i);
    sw_i = q;
    @(negedge core_clk_i);
    sw_i = '0;
  endtask

  task automatic setup(input count_t pre, input count_t rld);
    sw_req_s q;
    q = '0;
    q.cnt_wr = 1'b1;
    q.cnt_data = pre;
    q.rld_wr = 1'b1;
    q.rld_data = rld;
    send(q);
  endtask

  task automatic write_cen(input logic v, input logic unlock);
    sw_req_s q;
    q = '0;
    q.cen_wr = 1'b1;
    q.cen_data = v;
    q.cen_unlock = unlock;
    send(q);
  endtask

  task automatic note(input int gap, input logic ff, input logic cen, input logic h,
                      input count_t nx);
    exp_q.push_back('{gap, ff, cen, h, nx});
  endtask

  task automatic drain;
    for (int k = 0; k < 500 && exp_q.size() != 0; k++)
      @(negedge core_clk_i);
    @(negedge core_clk_i);
    if (cnt(exp_q.size() != 0)) err("interrupt missing");
  endtask

  //////////////////////////////////////////////////
  // Timing is measured from the enable rising or the previous interrupt.
  always @(negedge core_clk_i)
  begin
    if (rst_done)
    begin
      cyc++;
      if (chk_next)
      begin
        chk_next = 1'b0;
        if (cnt(count_o !== nxt_val)) err("counter after reload wrong");
      end
      if (irq_o === 1'b1)
      begin
        if (exp_q.size() == 0)
          err("unexpected interrupt");
        else
        begin
          n = exp_q.pop_front();
          if (cnt(cyc - ref_cyc != n.gap)) err("interrupt at wrong time");
          if (cnt(ff_o !== n.ff)) err("output level wrong");
          if (cnt(cen_o !== n.cen)) err("enable status wrong");
          if (cnt(count_o !== 16'hffff)) err("counter not all ones");
          chk_next = n.has_nxt;
          nxt_val = n.nxt;
        end
        ref_cyc = cyc;
      end
      else if (cen_o === 1'b1 && cen_prev !== 1'b1)
        ref_cyc = cyc;
      cen_prev = cen_o;
    end
  end

  always @(posedge core_clk_i)
  begin
    ticks++;
    if (ticks == 20000)
    begin
      err("run hung");
      test_done();
    end
  end

  //////////////////////////////////////////////////
  initial
  begin
    void'($urandom(32'h96c9498e));
    repeat (3) @(negedge core_clk_i);
    if (cnt(cen_o !== 1'b0 || ff_o !== 1'b0 || irq_o !== 1'b0)) err("reset values");
    nrst_i = 1'b1;
    repeat (4) @(negedge core_clk_i);
    rst_done = 1'b1;
    for (int i = 0; i < 3; i++)
    begin
      p = 2 + $urandom_range(30);
      r = 1 + $urandom_range(14);
      setup(count_t'(p), count_t'(r));
      write_cen(1'b1, 1'b0);
      repeat (2) @(negedge core_clk_i);
      if (cnt(cen_o !== 1'b0)) err("enable changed while locked");
      note(p + 2, ~ffx, 1'b1, 1'b1, count_t'(r - 1));
      note(r + 1, ffx, 1'b0, 1'b0, 16'h0000);
      write_cen(1'b1, 1'b1);
      drain();
    end
    // Lengthen by four with plus three, then shorten by one with minus two, which wraps the counter.
    for (int i = 0; i < 2; i++)
    begin
      d = (i == 0) ? 3 : -2;
      setup(16'h000c, 16'h0003);
      note(15 + d, ~ffx, 1'b1, 1'b1, 16'h0002);
      note(4, ffx, 1'b0, 1'b0, 16'h0000);
      write_cen(1'b1, 1'b1);
      repeat (2) @(negedge core_clk_i);
      send('{corr_wr: 1'b1, corr_data: count_t'(d), default: '0});
      drain();
    end
    // Software enable written in the stopping tick keeps the enable bit set.
    setup(16'h0004, 16'h0003);
    note(6, ~ffx, 1'b1, 1'b1, 16'h0002);
    note(4, ffx, 1'b1, 1'b0, 16'h0000);
    write_cen(1'b1, 1'b1);
    for (int k = 0; k < 50 && irq_o !== 1'b1; k++)
      @(negedge core_clk_i);
    repeat (3) @(negedge core_clk_i);
    sw_i = '{cen_wr: 1'b1, cen_data: 1'b1, cen_unlock: 1'b1, default: '0};
    @(negedge core_clk_i);
    sw_i = '{cen_wr: 1'b1, cen_unlock: 1'b1, default: '0};
    @(negedge core_clk_i);
    sw_i = '0;
    if (cnt(cen_o !== 1'b0)) err("disable ignored");
    drain();
    // An external rise in the stopping tick loses to the stop.
    setup(16'h0004, 16'h0003);
    note(6, ~ffx, 1'b1, 1'b1, 16'h0002);
    note(4, ffx, 1'b0, 1'b0, 16'h0000);
    write_cen(1'b1, 1'b1);
    for (int k = 0; k < 50 && irq_o !== 1'b1; k++)
      @(negedge core_clk_i);
    @(negedge core_clk_i);
    ext_enable_i = 1'b1;
    drain();
    ext_enable_i = 1'b0;
    if (cnt(cen_o !== 1'b0)) err("external enable beat the stop");
    // Continuous mode started from the pin; only software stops it.
    mode_i = MODE_CONTINUOUS;
    r = 5 + $urandom_range(8);
    setup(16'h0005, count_t'(r));
    note(7, ffx, 1'b1, 1'b1, count_t'(r - 1));
    for (int i = 0; i < 3; i++)
      note(r + 1, (i % 2 == 0) ? ~ffx : ffx, 1'b1, 1'b1, count_t'(r - 1));
    @(negedge core_clk_i);
    ext_enable_i = 1'b1;
    drain();
    write_cen(1'b0, 1'b1);
    repeat (2) @(negedge core_clk_i);
    ext_enable_i = 1'b0;
    if (cnt(cen_o !== 1'b0)) err("continuous run not stopped");
    repeat (30) @(negedge core_clk_i);
    test_done();
  end
endmodule // testbench

`default_nettype wire
